// ===== bench/wbx_master_test.sv
// Self-checking bench for the wide bus extension master
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin total_checks++; if ((sn) !== (ex)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, sn); end end
module wbx_master_test;
  logic        sys_clk = 0, rst = 1, start = 0, is_write = 0, use_dac = 0;
  logic        want64 = 1, last = 1, frame_n = 1, irdy_n = 1, wide = 1, bad = 0;
  logic [3:0]  cmd = 4'h0, wbe_hi_n = 4'hF, cbe_hi_n_o, cbe_hi_n_i, c_cbe, c_cbed;
  logic [31:0] addr_hi = 0, wdata_hi = 0, rdata = 0, rdata_hi, ad_hi_o, ad_hi_i, t_ad;
  logic [31:0] c_adr, c_ad, c_rd;
  logic        busy, wide_ok, rdata_valid, par_err, req64_at_reset, ad_hi_oe_n;
  logic        cbe_hi_oe_n, req64_n_o, req64_oe_n, req64_n_i, par64_o, par64_oe_n;
  logic        par64_i, t_par, devsel_n, trdy_n, ack64_n, c_para, c_pard, c_poe, c_wok, c_pe;
  logic        rst_dly = 1, c_req;
  int          n_mismatch = 0, total_checks = 0;
  // Central resource keeps the width strap one clock past reset release
  always @(posedge sys_clk) rst_dly <= rst;
  assign ad_hi_i    = ad_hi_oe_n ? t_ad : ad_hi_o;
  assign cbe_hi_n_i = cbe_hi_oe_n ? 4'hF : cbe_hi_n_o;
  assign par64_i    = par64_oe_n ? t_par : par64_o;
  assign req64_n_i  = req64_oe_n ? !(rst || rst_dly) : req64_n_o;
  wbx_master u_wbx_master (.sys_clk, .rst, .start, .is_write, .use_dac, .want64, .cmd,
    .addr_hi, .wdata_hi, .wbe_hi_n, .last, .busy, .wide_ok, .rdata_hi, .rdata_valid,
    .par_err, .req64_at_reset, .frame_n, .irdy_n, .trdy_n, .devsel_n, .ad_hi_i, .ad_hi_o,
    .ad_hi_oe_n, .cbe_hi_n_i, .cbe_hi_n_o, .cbe_hi_oe_n, .req64_n_i, .req64_n_o,
    .req64_oe_n, .ack64_n_i(ack64_n), .par64_i, .par64_o, .par64_oe_n);
  wbx_tgt_model u_wbx_tgt_model (.sys_clk, .rst, .wide, .bad, .rdata, .frame_n, .irdy_n,
    .cbe_hi_n(cbe_hi_n_i), .devsel_n, .trdy_n, .ack64_n, .ad_hi(t_ad), .par64(t_par));
  initial forever #25 sys_clk = ~sys_clk;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // One transaction, lower core played by the bench
  // ------------------------------------------------------------
  task automatic run(input logic w, d, input logic [3:0] cm, be, input logic [31:0] ah, wd);
    int ph;
    ph = 0;
    c_rd = 0;
    c_pe = 0;
    @(posedge sys_clk);
    is_write <= w;
    use_dac  <= d;
    cmd      <= cm;
    wbe_hi_n <= be;
    addr_hi  <= ah;
    wdata_hi <= wd;
    start    <= 1'h1;
    @(posedge sys_clk);
    start   <= 1'h0;
    frame_n <= 1'h0;
    @(negedge sys_clk);
    c_adr = ad_hi_o;
    c_cbe = cbe_hi_n_o;
    c_req = req64_n_o;
    @(posedge sys_clk);
    @(negedge sys_clk);
    c_para = par64_o;
    @(posedge sys_clk);
    irdy_n  <= 1'h0;
    frame_n <= 1'h1;
    for (int k = 0; k < 10; k++) begin
      @(negedge sys_clk);
      if (rdata_valid === 1'h1) c_rd = rdata_hi;
      if (par_err === 1'h1) c_pe = 1'h1;
      if (ph == 1) begin
        c_pard = par64_i;
        c_poe  = par64_oe_n;
        ph     = 2;
      end
      if (ph == 0 && trdy_n === 1'h0 && irdy_n === 1'h0) begin
        c_ad   = ad_hi_i;
        c_cbed = cbe_hi_n_o;
        c_wok  = wide_ok;
        ph     = 1;
      end
      @(posedge sys_clk);
      if (ph == 1) irdy_n <= 1'h1;
    end
    if (ph != 2 || busy !== 1'h0) begin
      n_mismatch++;
      print_verdict;
    end
  endtask
  task automatic t_reset;
    @(negedge sys_clk);
    `CHK("req64 oe", 1'h1, req64_oe_n)
    @(posedge sys_clk);
    rst <= 1'h0;
    repeat (2) @(negedge sys_clk);
    `CHK("req64 rst", 1'h1, req64_at_reset)
  endtask
  task automatic t_wide_write;
    run(1'h1, 1'h0, 4'h7, 4'h5, 32'h0, 32'hA5C3_0F97);
    `CHK("wdata", 32'hA5C3_0F97, c_ad)
    `CHK("wbe", 4'h5, c_cbed)
    `CHK("par wr", ^{32'hA5C3_0F97, 4'h5}, c_pard)
    `CHK("par drv", 1'h0, c_poe)
    `CHK("wide", 1'h1, c_wok)
    `CHK("req64", 1'h0, c_req)
  endtask
  task automatic t_dac;
    run(1'h1, 1'h1, 4'h7, 4'h0, 32'h0000_0001, 32'h1234_5678);
    `CHK("adr hi", 32'h0000_0001, c_adr)
    `CHK("dac cmd", 4'h7, c_cbe)
    `CHK("par adr", ^{32'h0000_0001, 4'h7}, c_para)
    `CHK("dac data", 32'h1234_5678, c_ad)
  endtask
  task automatic t_read(input logic b);
    bad   <= b;
    rdata <= 32'h0F1E_2D3C;
    run(1'h0, 1'h0, 4'h6, 4'h0, 32'h0, 32'h0);
    `CHK("rdata", 32'h0F1E_2D3C, c_rd)
    `CHK("perr", b, c_pe)
    `CHK("par src", 1'h1, c_poe)
  endtask
  task automatic t_narrow;
    wide <= 1'h0;
    run(1'h1, 1'h0, 4'h7, 4'h0, 32'h0, 32'h5);
    `CHK("narrow", 1'h0, c_wok)
    wide <= 1'h1;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    t_reset;
    t_wide_write;
    t_dac;
    t_read(1'h0);
    t_read(1'h1);
    t_narrow;
    print_verdict;
  end
endmodule

// ===== bench/wbx_tgt_model.sv
// Behavioural target agent answering on the upper lanes
`timescale 1ns/1ps
module wbx_tgt_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Bench controls
  input  wire logic        wide,
  input  wire logic        bad,
  input  wire logic [31:0] rdata,
  // Bus side, upper pin group present except req64
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  input  wire logic [3:0]  cbe_hi_n,
  output logic             devsel_n,
  output logic             trdy_n,
  output logic             ack64_n,
  output logic [31:0]      ad_hi,
  output logic             par64
);
  logic hold_q;
  always_ff @(posedge sys_clk) begin
    hold_q <= !trdy_n;
    if (rst) begin
      devsel_n <= 1'h1;
      trdy_n   <= 1'h1;
      ack64_n  <= 1'h1;
      ad_hi    <= 32'h0;
    end else if (!trdy_n && !irdy_n) begin
      devsel_n <= 1'h1;
      trdy_n   <= 1'h1;
      ack64_n  <= 1'h1;
      ad_hi    <= ~ad_hi;
    end else if (!frame_n && devsel_n) begin
      devsel_n <= 1'h0;
      trdy_n   <= 1'h0;
      ack64_n  <= !wide;
      ad_hi    <= rdata;
    end
    // Released parity flips so a stale value never looks valid
    if (rst) par64 <= 1'h0;
    else if (!trdy_n) par64 <= ^{ad_hi, cbe_hi_n} ^ bad;
    else if (!hold_q) par64 <= ~par64;
  end
endmodule

// ===== hw/wbx_master.sv
// Host-side master for the upper 32-bit lanes of a parallel bus agent
// ---------------------------------------------------------------
// Functional notes
// ---------------------------------------------------------------
`timescale 1ns/1ps
module wbx_master (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // User side
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic        use_dac,
  input  wire logic        want64,
  input  wire logic [3:0]  cmd,
  input  wire logic [31:0] addr_hi,
  input  wire logic [31:0] wdata_hi,
  input  wire logic [3:0]  wbe_hi_n,
  input  wire logic        last,
  output logic             busy,
  output logic             wide_ok,
  output logic [31:0]      rdata_hi,
  output logic             rdata_valid,
  output logic             par_err,
  output logic             req64_at_reset,
  // Lower core signals (observed)
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  input  wire logic        trdy_n,
  input  wire logic        devsel_n,
  // Extension pins
  input  wire logic [31:0] ad_hi_i,
  output logic [31:0]      ad_hi_o,
  output logic             ad_hi_oe_n,
  input  wire logic [3:0]  cbe_hi_n_i,
  output logic [3:0]       cbe_hi_n_o,
  output logic             cbe_hi_oe_n,
  input  wire logic        req64_n_i,
  output logic             req64_n_o,
  output logic             req64_oe_n,
  input  wire logic        ack64_n_i,
  input  wire logic        par64_i,
  output logic             par64_o,
  output logic             par64_oe_n
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADR1 = 3'b001,
    ST_ADR2 = 3'b010,
    ST_DATA = 3'b011,
    ST_TURN = 3'b100
  } wbx_state_t;

  typedef struct packed {
    wbx_state_t  st;
    logic        wr;
    logic        dac;
    logic        wide;
    logic        ack_seen;
    logic [31:0] ad;
    logic [3:0]  cbe;
    logic        ad_oe_n;
    logic        req_n;
    logic        req_oe_n;
    logic        par;
    logic        par_oe_n;
    logic        chk_pend;
    // Parity owed by the upper lanes of the last wide read word
    logic        rpar;
    logic [31:0] rd;
    logic        rd_v;
    logic        perr;
    logic        strap;
    logic        rst_d;
    logic        strap_done;
  } wbx_reg_t;

  wbx_reg_t r_q, r_d;
  logic     data_xfer;
  logic     rx_par;

  assign data_xfer = !irdy_n && !trdy_n;
  assign rx_par    = ^{ad_hi_i, cbe_hi_n_i};

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    r_d          = r_q;
    r_d.rd_v     = 1'b0;
    r_d.perr     = 1'b0;
    r_d.rst_d    = rst;
    // Parity trails lanes by one clock, only over driven lanes
    r_d.par      = ^{r_q.ad, r_q.cbe};
    r_d.par_oe_n = r_q.ad_oe_n;
    // Strap sampled at the clock after reset releases
    if (r_q.rst_d && !r_q.strap_done) begin
      r_d.strap      = !req64_n_i;
      r_d.strap_done = 1'b1;
    end
    // Read parity check one clock after each wide read transfer
    r_d.chk_pend = 1'b0;
    // Lanes may already carry the next word, so compare with the latched value
    if (r_q.chk_pend && par64_i != r_q.rpar) begin
      r_d.perr = 1'b1;
    end
    case (r_q.st)
      ST_IDLE: begin
        r_d.ad_oe_n  = 1'b1;
        r_d.req_oe_n = 1'b1;
        if (start && frame_n && irdy_n) begin
          r_d.wr       = is_write;
          r_d.dac      = use_dac;
          r_d.wide     = want64;
          r_d.ack_seen = 1'b0;
          r_d.req_n    = !want64;
          r_d.req_oe_n = 1'b0;
          r_d.ad_oe_n  = 1'b0;
          // Upper lanes hold stable filler outside the address phases of a wide DAC
          r_d.ad  = (use_dac && want64) ? addr_hi : wbx_pkg::HI_IDLE;
          r_d.cbe = (use_dac && want64) ? cmd : wbx_pkg::BE_NONE;
          // Dual cycle only on request, so narrow-only targets never see it
          r_d.st  = use_dac ? ST_ADR1 : ST_ADR2;
        end
      end
      ST_ADR1: begin
        // First address phase of a dual cycle
        r_d.st = ST_ADR2;
      end
      ST_ADR2: begin
        r_d.st = ST_DATA;
        if (r_q.wr && r_q.wide) begin
          r_d.ad  = wdata_hi;
          r_d.cbe = wbe_hi_n;
        end else begin
          r_d.ad_oe_n = 1'b1;
        end
      end
      ST_DATA: begin
        // Width answer is judged once, in the clock that claims the access
        if (!devsel_n && !r_q.ack_seen) begin
          r_d.ack_seen = 1'b1;
          // Target refused width: drop to lower lanes only
          if (ack64_n_i) begin
            r_d.wide    = 1'b0;
            r_d.ad_oe_n = 1'b1;
          end
        end
        if (data_xfer) begin
          if (!r_q.wr && r_q.wide && !ack64_n_i) begin
            r_d.rd       = ad_hi_i;
            r_d.rd_v     = 1'b1;
            r_d.chk_pend = 1'b1;
            r_d.rpar     = rx_par;
          end
          if (r_q.wr && r_q.wide) begin
            r_d.ad  = wdata_hi;
            r_d.cbe = wbe_hi_n;
          end
          if (last) begin
            r_d.req_n = 1'b1;
            r_d.st    = ST_TURN;
          end
        end
      end
      ST_TURN: begin
        // Drive high one clock, then release
        r_d.req_oe_n = 1'b1;
        r_d.ad_oe_n  = 1'b1;
        r_d.st       = ST_IDLE;
      end
      default: r_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r_q          <= '0;
      r_q.st       <= ST_IDLE;
      r_q.cbe      <= wbx_pkg::BE_NONE;
      r_q.ad_oe_n  <= 1'b1;
      r_q.req_n    <= 1'b1;
      r_q.req_oe_n <= 1'b1;
      r_q.par_oe_n <= 1'b1;
      r_q.rst_d    <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs: ad_hi and cbe_hi_n share one enable, req64 and par64 have their own
  // ---------------------------------------------------------------
  assign ad_hi_o        = r_q.ad;
  assign ad_hi_oe_n     = r_q.ad_oe_n;
  assign cbe_hi_n_o     = r_q.cbe;
  assign cbe_hi_oe_n    = r_q.ad_oe_n;
  assign req64_n_o      = r_q.req_n;
  assign req64_oe_n     = r_q.req_oe_n;
  assign par64_o        = r_q.par;
  assign par64_oe_n     = r_q.par_oe_n;
  assign busy           = (r_q.st != ST_IDLE);
  assign wide_ok        = r_q.wide;
  assign rdata_hi       = r_q.rd;
  assign rdata_valid    = r_q.rd_v;
  assign par_err        = r_q.perr;
  assign req64_at_reset = r_q.strap;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_par_even: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(r_q.ad_oe_n) |-> (par64_o == ^$past({ad_hi_o, cbe_hi_n_o})))
    else $error("upper parity not even");
  chk_par_trail: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(ad_hi_oe_n) |=> $fell(par64_oe_n))
    else $error("parity enable does not trail lanes");
  chk_req_release: assert property (@(posedge sys_clk) disable iff (rst)
    (r_q.st == ST_TURN) |=> req64_oe_n ##1 1'b1)
    else $error("width request not released after turn");
  chk_dac_cmd: assert property (@(posedge sys_clk) disable iff (rst)
    (r_q.st == ST_IDLE && start && frame_n && irdy_n && use_dac && want64)
      |=> (cbe_hi_n_o == $past(cmd) && !cbe_hi_oe_n))
    else $error("dual cycle command missing");
  chk_fallback: assert property (@(posedge sys_clk) disable iff (rst)
    (r_q.st == ST_DATA && !devsel_n && !r_q.ack_seen && ack64_n_i) |=> !wide_ok)
    else $error("no fall back to narrow lanes");
  chk_perr_flag: assert property (@(posedge sys_clk) disable iff (rst)
    (r_q.chk_pend && par64_i != r_q.rpar) |=> par_err)
    else $error("parity mismatch not flagged");
  chk_read_hiz: assert property (@(posedge sys_clk) disable iff (rst)
    (r_q.st == ST_DATA && !r_q.wr) |-> ad_hi_oe_n)
    else $error("master drives lanes on read");
  chk_rd_wide: assert property (@(posedge sys_clk) disable iff (rst)
    rdata_valid |-> ($past(!ack64_n_i) && $past(data_xfer)))
    else $error("upper data taken without width ack");

  // ---------------------------------------------------------------
  // Lane contents per phase
  // ---------------------------------------------------------------
  chk_dac_addr: assert property (@(posedge sys_clk) disable iff (rst)
    (r_q.st == ST_IDLE && start && frame_n && irdy_n && use_dac && want64)
      |=> (ad_hi_o == $past(addr_hi)))
    else $error("high address half missing");
  chk_idle_filler: assert property (@(posedge sys_clk) disable iff (rst)
    (r_q.st == ST_IDLE && start && frame_n && irdy_n && !use_dac)
      |=> (ad_hi_o == wbx_pkg::HI_IDLE && cbe_hi_n_o == wbx_pkg::BE_NONE))
    else $error("upper lanes not at filler value");
  chk_wr_data: assert property (@(posedge sys_clk) disable iff (rst)
    (r_q.st == ST_ADR2 && r_q.wr && r_q.wide) |=> (ad_hi_o == $past(wdata_hi)))
    else $error("upper write word not on lanes");
  chk_wr_be: assert property (@(posedge sys_clk) disable iff (rst)
    (r_q.st == ST_ADR2 && r_q.wr && r_q.wide) |=> (cbe_hi_n_o == $past(wbe_hi_n)))
    else $error("upper byte enables not on lanes");
  chk_rd_word: assert property (@(posedge sys_clk) disable iff (rst)
    rdata_valid |-> (rdata_hi == $past(ad_hi_i)))
    else $error("upper read word not taken from lanes");

  // ---------------------------------------------------------------
  // Ownership and hand-back of the extension pins
  // ---------------------------------------------------------------
  chk_par_hold: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(ad_hi_oe_n) |-> !par64_oe_n)
    else $error("parity released with its lanes");
  chk_req_turn: assert property (@(posedge sys_clk) disable iff (rst)
    (r_q.st == ST_TURN) |-> req64_n_o)
    else $error("width request still asserted in turn");
  chk_idle_release: assert property (@(posedge sys_clk) disable iff (rst)
    (r_q.st == ST_IDLE) |-> req64_oe_n)
    else $error("width request driven while idle");
  chk_strap_once: assert property (@(posedge sys_clk) disable iff (rst)
    $past(r_q.strap_done) |-> $stable(req64_at_reset))
    else $error("reset width strap changed after capture");
  chk_narrow_lanes: assert property (@(posedge sys_clk) disable iff (rst)
    (r_q.st == ST_DATA && r_q.ack_seen && !wide_ok) |-> ad_hi_oe_n)
    else $error("upper lanes driven after narrow answer");

  cov_dac:    cover property (@(posedge sys_clk) r_q.st == ST_ADR1);
  cov_wrd64:  cover property (@(posedge sys_clk) r_q.wr && wide_ok && data_xfer);
  cov_rd64:   cover property (@(posedge sys_clk) rdata_valid);
  cov_narrow: cover property (@(posedge sys_clk) r_q.ack_seen && !wide_ok);
  cov_perr:   cover property (@(posedge sys_clk) par_err);
endmodule

// ===== hw/wbx_pkg.sv
// Package: constants for the wide bus extension master controller
package wbx_pkg;
  localparam int          LO_W      = 32;
  localparam int          HI_W      = 32;
  localparam int          BE_W      = 4;
  localparam logic [3:0]  CMD_DAC   = 4'hD;
  localparam logic [3:0]  BE_NONE   = 4'hF;
  localparam logic [31:0] HI_IDLE   = 32'h0000_0000;
  localparam logic [2:0]  CNT_ONE   = 3'h1;
endpackage
